//--- hdl/bridge_reset_sequencer.sv
// Bridge end: combines power-on, global and fundamental resets
`timescale 1ns/1ps
`default_nettype none
module bridge_reset_sequencer
    import rst_seq_pkg::*;
#(
    parameter int CLK_WAIT_CYC = CLK_STABLE_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    rst_link_if.bridge link,
    input wire logic global_reset_in_n,
    input wire logic [SUPPLY_W-1:0] core_supply_sense,
    input wire logic [STRAP_W-1:0] strap_in,
    input wire logic eeprom_present_in,
    input wire logic eeprom_done_in,
    input wire logic hot_reset_in,
    input wire logic secondary_bus_reset_bit,
    input wire logic [7:0] ctrl_wdata_in,
    input wire logic ctrl_we_in,
    input wire logic [7:0] sticky_wdata_in,
    input wire logic sticky_we_in,
    output logic por_rst_n_out,
    output logic link_rst_n_out,
    output logic sec_bus_rst_n_out,
    output logic [STRAP_W-1:0] strap_out,
    output logic eeprom_start_out,
    output logic link_init_out,
    output logic train_start_out,
    output logic data_link_down_out,
    output logic [7:0] ctrl_reg_out,
    output logic [7:0] sticky_reg_out
);
    import rst_seq_pkg::*;

    // ****************************************************************
    // Reset source combination
    // ****************************************************************
    logic [2:0] por_sync;
    logic [2:0] link_sync;
    logic [CNT_W-1:0] clk_cnt;
    logic por_rst_n;
    logic link_rst_n;
    logic prev_link_rst_n;
    seq_state_t state;
    seq_state_t next_state;
    logic [CNT_W-1:0] train_cnt;

    // Supply good and clock seen; global reset bypasses the clock
    wire supply_good = core_supply_sense >= SUPPLY_GOOD;
    wire por_src_n = global_reset_in_n & supply_good & link.supply_on;
    wire link_src_n = link.fund_reset_n & ~hot_reset_in;
    wire clk_wait_done = clk_cnt >= CLK_WAIT_CYC[CNT_W-1:0];

    // Power-on release waits 10 us of running reference clock
    always_ff @(posedge clk_in or negedge por_src_n) begin
        if (!por_src_n) begin
            clk_cnt <= '0;
        end else if (!link.refclk_active) begin
            clk_cnt <= '0;
        end else if (!clk_wait_done) begin
            clk_cnt <= clk_cnt + 1'b1;
        end
    end

    // Asynchronous assert, synchronous release
    always_ff @(posedge clk_in or negedge por_src_n) begin
        if (!por_src_n) begin
            por_sync <= 3'h0;
        end else begin
            por_sync <= {por_sync[1:0], clk_wait_done & rst_n_in};
        end
    end
    assign por_rst_n = por_sync[2];

    // Link reset domain includes power-on reset
    wire link_any_n = link_src_n & por_src_n;
    always_ff @(posedge clk_in or negedge link_any_n) begin
        if (!link_any_n) begin
            link_sync <= 3'h0;
        end else begin
            link_sync <= {link_sync[1:0], por_rst_n};
        end
    end
    assign link_rst_n = link_sync[2];

    // ****************************************************************
    // EEPROM pin filters
    // ****************************************************************
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] pin_s3;
    logic [1:0] pin_clean;
    // A pin change counts only once the last two stages agree
    wire [1:0] pin_agree = ~(pin_s2 ^ pin_s3);
    wire [1:0] next_pin_clean = (pin_agree & pin_s3) | (~pin_agree & pin_clean);
    wire eeprom_present = pin_clean[0];
    wire eeprom_done = pin_clean[1];

    // Three flops per pin keep the handshake off metastable edges
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            pin_s3 <= 2'h0;
            pin_clean <= 2'h0;
        end else begin
            pin_s1 <= {eeprom_done_in, eeprom_present_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_clean <= next_pin_clean;
        end
    end

    // ****************************************************************
    // Registers per reset domain
    // ****************************************************************
    // Sticky bits cleared only by power-on or global reset
    always_ff @(posedge clk_in or negedge por_rst_n) begin
        if (!por_rst_n) begin
            sticky_reg_out <= STICKY_RESET;
        end else if (sticky_we_in) begin
            sticky_reg_out <= sticky_wdata_in;
        end
    end

    // Non-sticky control cleared by any reset
    always_ff @(posedge clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ctrl_reg_out <= CTRL_RESET;
        end else if (ctrl_we_in) begin
            ctrl_reg_out <= ctrl_wdata_in;
        end
    end

    // ****************************************************************
    // Post-release sequence
    // ****************************************************************
    wire train_due = train_cnt >= TRAIN_START_CYC[CNT_W-1:0];

    // One-hot state test shared by strap capture and load start
    function automatic logic at_state(input seq_state_t cur, input seq_state_t want);
        return (cur & want) != 5'h00;
    endfunction : at_state
    wire in_latch = at_state(state, ST_LATCH);

    // Next state decode
    always_comb begin
        next_state = state;
        case (state)
            ST_RESET: next_state = ST_LATCH;
            ST_LATCH: next_state = eeprom_present ? ST_LOAD : ST_WAIT;
            ST_LOAD: next_state = eeprom_done ? ST_WAIT : ST_LOAD;
            ST_WAIT: next_state = train_due ? ST_TRAIN : ST_WAIT;
            ST_TRAIN: next_state = ST_TRAIN;
            default: next_state = ST_RESET;
        endcase
    end

    // State machine and training counter; non-sticky machines clear on link reset
    always_ff @(posedge clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state <= ST_RESET;
            train_cnt <= '0;
        end else begin
            state <= next_state;
            train_cnt <= train_due ? train_cnt : train_cnt + 1'b1;
        end
    end

    // Straps caught in ST_LATCH, the cycle after the release, never under asynchronous reset
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            strap_out <= '0;
            prev_link_rst_n <= 1'b0;
        end else begin
            prev_link_rst_n <= link_rst_n;
            if (in_latch) begin
                strap_out <= strap_in;
            end
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign por_rst_n_out = por_rst_n;
    assign link_rst_n_out = link_rst_n;
    assign sec_bus_rst_n_out = link_rst_n & ~secondary_bus_reset_bit;
    assign eeprom_start_out = in_latch & eeprom_present;
    assign link_init_out = (state != ST_RESET);
    assign train_start_out = (state == ST_TRAIN);
    assign data_link_down_out = ~link_rst_n | ~prev_link_rst_n;
endmodule : bridge_reset_sequencer
`default_nettype wire

//--- hdl/rst_link_if.sv
// Interface joining the upstream host and the bridge reset sequencer
`timescale 1ns/1ps
`default_nettype none
interface rst_link_if;
    logic fund_reset_n;
    logic refclk_active;
    logic supply_on;
    modport host (output fund_reset_n, output refclk_active, output supply_on);
    modport bridge (input fund_reset_n, input refclk_active, input supply_on);
endinterface : rst_link_if
`default_nettype wire

//--- hdl/rst_seq_pkg.sv
// Package with reset sequencer constants and the bridge and host state types
package rst_seq_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CLK_MHZ = 200;
    localparam int CLK_STABLE_US = 10;
    localparam int CLK_STABLE_CYC = CLK_STABLE_US * CLK_MHZ;
    localparam int TRAIN_LIMIT_MS = 80;
    localparam int TRAIN_LIMIT_CYC = TRAIN_LIMIT_MS * 1000 * CLK_MHZ;
    localparam int HOST_CLK_US = 100;
    localparam int HOST_CLK_CYC = HOST_CLK_US * CLK_MHZ;
    localparam int HOST_PWR_MS = 100;
    localparam int HOST_PWR_CYC = HOST_PWR_MS * 1000 * CLK_MHZ;
    localparam int TRAIN_START_CYC = 16;
    localparam int CNT_W = 25;
    // ****************************************************************
    // Fields
    // ****************************************************************
    localparam int STRAP_W = 8;
    localparam int SUPPLY_W = 8;
    localparam logic [7:0] SUPPLY_GOOD = 8'he6; // 90% of full scale 8'hff
    localparam int BRIDGE_CTRL_OFFSET = 32'h3e;
    localparam int SEC_RESET_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STICKY_RESET = 8'h00;
    // ****************************************************************
    // States
    // ****************************************************************
    typedef enum logic [4:0] {
        ST_RESET = 5'h01,
        ST_LATCH = 5'h02,
        ST_LOAD = 5'h04,
        ST_WAIT = 5'h08,
        ST_TRAIN = 5'h10
    } seq_state_t;
    typedef enum logic [4:0] {
        H_OFF = 5'h01,
        H_PWR = 5'h02,
        H_CLK = 5'h04,
        H_RUN = 5'h08,
        H_DOWN = 5'h10
    } host_state_t;
endpackage : rst_seq_pkg

//--- hdl/upstream_reset_host.sv
// Host end: orders supplies, reference clock and fundamental reset
`timescale 1ns/1ps
`default_nettype none
module upstream_reset_host
    import rst_seq_pkg::*;
#(
    parameter int PWR_WAIT_CYC = HOST_PWR_CYC,
    parameter int CLK_WAIT_CYC = HOST_CLK_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic power_req_in,
    output logic link_up_out,
    rst_link_if.host link
);
    import rst_seq_pkg::*;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    host_state_t state;
    host_state_t next_state;
    logic [CNT_W-1:0] pwr_cnt;
    logic [CNT_W-1:0] clk_cnt;
    wire pwr_done = pwr_cnt >= PWR_WAIT_CYC[CNT_W-1:0];
    wire clk_done = clk_cnt >= CLK_WAIT_CYC[CNT_W-1:0];

    // Next state decode
    always_comb begin
        next_state = state;
        case (state)
            H_OFF: next_state = power_req_in ? H_PWR : H_OFF;
            H_PWR: next_state = power_req_in ? H_CLK : H_DOWN;
            H_CLK: next_state = !power_req_in ? H_DOWN :
                (pwr_done && clk_done) ? H_RUN : H_CLK;
            H_RUN: next_state = power_req_in ? H_RUN : H_DOWN;
            H_DOWN: next_state = H_OFF;
            default: next_state = H_OFF;
        endcase
    end

    // State and delay counters
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state <= H_OFF;
            pwr_cnt <= '0;
            clk_cnt <= '0;
        end else begin
            state <= next_state;
            pwr_cnt <= (state == H_OFF) ? '0 : (pwr_done ? pwr_cnt : pwr_cnt + 1'b1);
            clk_cnt <= (state != H_CLK) ? '0 : (clk_done ? clk_cnt : clk_cnt + 1'b1);
        end
    end

    // Reset stays low until run; clock stops before supplies drop
    assign link.fund_reset_n = (state == H_RUN);
    assign link.refclk_active = (state == H_CLK) | (state == H_RUN);
    assign link.supply_on = (state != H_OFF);
    assign link_up_out = (state == H_RUN);
endmodule : upstream_reset_host
`default_nettype wire

//--- verification/rst_link_props.sv
// Checker for the reset link between host and bridge
`timescale 1ns/1ps
`default_nettype none
module rst_link_props #(
    parameter int PWR_CYC = 20,
    parameter int CLK_CYC = 10
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic fund_reset_n,
    input wire logic refclk_active,
    input wire logic supply_on,
    input wire logic global_reset_in_n,
    input wire logic secondary_bus_reset_bit,
    input wire logic link_rst_n_out,
    input wire logic por_rst_n_out,
    input wire logic sec_bus_rst_n_out
);
    int clk_cnt;
    int pwr_cnt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ****************************************************************
    // Cycles spent with clock and supply up
    // ****************************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            clk_cnt <= 0;
            pwr_cnt <= 0;
        end else begin
            clk_cnt <= refclk_active ? clk_cnt + 1 : 0;
            pwr_cnt <= supply_on ? pwr_cnt + 1 : 0;
        end
    end
    // ****************************************************************
    // Ordering on the link
    // ****************************************************************
    pwr_order_a: assert property ($rose(supply_on) |-> !fund_reset_n && !refclk_active)
        else $error("supply came up out of order");
    clk_order_a: assert property ($rose(refclk_active) |-> supply_on && !fund_reset_n)
        else $error("clock came up out of order");
    clk_hold_a: assert property ($rose(fund_reset_n) |-> clk_cnt >= CLK_CYC - 1)
        else $error("reset released too soon after clock");
    pwr_hold_a: assert property ($rose(fund_reset_n) |-> pwr_cnt >= PWR_CYC - 1)
        else $error("reset released too soon after power");
    clk_stop_a: assert property ($fell(refclk_active) |-> !fund_reset_n)
        else $error("clock stopped with reset released");
    supply_off_a: assert property ($fell(supply_on) |-> !fund_reset_n && !refclk_active)
        else $error("supply removed out of order");
    // ****************************************************************
    // Bridge reset outputs
    // ****************************************************************
    link_rst_a: assert property (!fund_reset_n |-> !link_rst_n_out && !sec_bus_rst_n_out)
        else $error("link reset not held");
    global_rst_a: assert property (!global_reset_in_n |-> !por_rst_n_out && !sec_bus_rst_n_out)
        else $error("global reset not obeyed");
    sec_bit_a: assert property (secondary_bus_reset_bit |-> !sec_bus_rst_n_out)
        else $error("secondary reset bit not obeyed");
endmodule : rst_link_props
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the host and bridge reset pair
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rst_seq_pkg::*;
    logic clk_in = 0, rst_n_in = 0, power_req_in = 0, link_up_out, hot_reset_in = 0;
    logic global_reset_in_n = 1, eeprom_present_in = 0, eeprom_done_in = 0;
    logic secondary_bus_reset_bit = 0, ctrl_we_in = 0, sticky_we_in = 0;
    logic [7:0] core_supply_sense = 8'hff, strap_in = 8'h00, ctrl_wdata_in = 8'h00;
    logic [7:0] sticky_wdata_in = 8'h00, strap_out, ctrl_reg_out, sticky_reg_out;
    logic por_rst_n_out, link_rst_n_out, sec_bus_rst_n_out, eeprom_start_out;
    logic link_init_out, train_start_out, data_link_down_out;
    int num_errors = 0, check_count = 0, seed = 32'h3c9e, ctrl_m = 0, sticky_m = 0, strap_m = 0;
    rst_link_if link ();
    upstream_reset_host #(.PWR_WAIT_CYC(20), .CLK_WAIT_CYC(10)) u_upstream_reset_host (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .power_req_in(power_req_in),
        .link_up_out(link_up_out), .link(link));
    bridge_reset_sequencer #(.CLK_WAIT_CYC(8)) u_bridge_reset_sequencer (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
        .global_reset_in_n(global_reset_in_n), .core_supply_sense(core_supply_sense),
        .strap_in(strap_in), .eeprom_present_in(eeprom_present_in),
        .eeprom_done_in(eeprom_done_in), .hot_reset_in(hot_reset_in),
        .secondary_bus_reset_bit(secondary_bus_reset_bit), .ctrl_wdata_in(ctrl_wdata_in),
        .ctrl_we_in(ctrl_we_in), .sticky_wdata_in(sticky_wdata_in),
        .sticky_we_in(sticky_we_in), .por_rst_n_out(por_rst_n_out),
        .link_rst_n_out(link_rst_n_out), .sec_bus_rst_n_out(sec_bus_rst_n_out),
        .strap_out(strap_out), .eeprom_start_out(eeprom_start_out),
        .link_init_out(link_init_out), .train_start_out(train_start_out),
        .data_link_down_out(data_link_down_out), .ctrl_reg_out(ctrl_reg_out),
        .sticky_reg_out(sticky_reg_out));
    rst_link_props #(.PWR_CYC(20), .CLK_CYC(10)) u_rst_link_props (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .fund_reset_n(link.fund_reset_n),
        .refclk_active(link.refclk_active), .supply_on(link.supply_on),
        .global_reset_in_n(global_reset_in_n), .secondary_bus_reset_bit(secondary_bus_reset_bit),
        .link_rst_n_out(link_rst_n_out), .por_rst_n_out(por_rst_n_out),
        .sec_bus_rst_n_out(sec_bus_rst_n_out));
    // 200 MHz clock
    always #2.5 clk_in = ~clk_in;
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : idle
    function automatic logic pick(input int k);
        return k == 0 ? train_start_out : (k == 1 ? eeprom_start_out : por_rst_n_out);
    endfunction : pick
    // Bounded wait for an output to go high
    task automatic wait_for(input int k, input string name);
        int n;
        n = 0;
        while (pick(k) !== 1'b1 && n < 2000) begin
            idle(1);
            n++;
        end
        chk(name, 8'h01, {7'h00, pick(k)});
    endtask : wait_for
    // Register write, model follows
    task automatic wr(input logic sticky, input logic [7:0] v);
        @(posedge clk_in);
        ctrl_wdata_in <= v;
        sticky_wdata_in <= v;
        ctrl_we_in <= !sticky;
        sticky_we_in <= sticky;
        @(posedge clk_in);
        ctrl_we_in <= 0;
        sticky_we_in <= 0;
        if (sticky) sticky_m = v;
        else ctrl_m = v;
        idle(1);
    endtask : wr
    task automatic regs();
        chk("ctrl", ctrl_m[7:0], ctrl_reg_out);
        chk("sticky", sticky_m[7:0], sticky_reg_out);
        chk("strap", strap_m[7:0], strap_out);
    endtask : regs
    task automatic final_report();
        $display("COUNTS checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // Watchdog
    initial begin
        #100000;
        num_errors++;
        final_report();
    end
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        repeat (8) @(posedge clk_in);
        rst_n_in <= 1;
        strap_in <= 8'h5a;
        strap_m = 8'h5a;
        power_req_in <= 1;
        wait_for(0, "train");
        regs();
        chk("link_up", 8'h01, {7'h00, link_up_out});
        chk("link_init", 8'h01, {7'h00, link_init_out});
        $display("TEST power-up done");
        wr(0, $random(seed));
        wr(1, $random(seed));
        regs();
        power_req_in <= 0;
        idle(40);
        chk("sec_bus", 8'h00, {7'h00, sec_bus_rst_n_out});
        chk("link_down", 8'h00, {7'h00, link_up_out});
        ctrl_m = 0;
        sticky_m = 0;
        strap_m = $random(seed) & 8'hff;
        strap_in <= strap_m[7:0];
        power_req_in <= 1;
        wait_for(0, "train");
        regs();
        $display("TEST fundamental reset done");
        wr(0, $random(seed));
        wr(1, $random(seed));
        hot_reset_in <= 1;
        idle(2);
        chk("train_off", 8'h00, {7'h00, train_start_out});
        chk("init_off", 8'h00, {7'h00, link_init_out});
        chk("dl_down", 8'h01, {7'h00, data_link_down_out});
        chk("sec_bus", 8'h00, {7'h00, sec_bus_rst_n_out});
        hot_reset_in <= 0;
        ctrl_m = 0;
        idle(40);
        regs();
        chk("dl_up", 8'h00, {7'h00, data_link_down_out});
        $display("TEST hot reset done");
        secondary_bus_reset_bit <= 1;
        idle(2);
        chk("sec_bit_on", 8'h00, {7'h00, sec_bus_rst_n_out});
        secondary_bus_reset_bit <= 0;
        idle(2);
        chk("sec_bit_off", 8'h01, {7'h00, sec_bus_rst_n_out});
        $display("TEST secondary reset done");
        core_supply_sense <= 8'he5;
        eeprom_present_in <= 1;
        strap_m = $random(seed) & 8'hff;
        strap_in <= strap_m[7:0];
        global_reset_in_n <= 0;
        idle(4);
        global_reset_in_n <= 1;
        idle(30);
        chk("por_low", 8'h00, {7'h00, por_rst_n_out});
        core_supply_sense <= 8'he6;
        wait_for(2, "por");
        wait_for(1, "eeprom");
        eeprom_done_in <= 1;
        wait_for(0, "train");
        ctrl_m = 0;
        sticky_m = 0;
        regs();
        $display("TEST global reset done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
